// file: pkg/dop_defines.svh
// register offsets, field positions, reset values and timing defaults of the display output path
`ifndef DOP_DEFINES_SVH
`define DOP_DEFINES_SVH
`define DOP_OFF_CTRL      8'h00
`define DOP_OFF_HDISP     8'h04
`define DOP_OFF_HNDP      8'h08
`define DOP_OFF_VDISP     8'h0C
`define DOP_OFF_VNDP      8'h10
`define DOP_OFF_GPTR      8'h14
`define DOP_OFF_GPORT     8'h18
`define DOP_OFF_STATUS    8'h1C
`define DOP_CTRL_SWAP     0
`define DOP_CTRL_RUN      1
`define DOP_ST_VND        0
`define DOP_ST_UNDERRUN   1
`define DOP_ST_EMPTY      2
`define DOP_RST_CTRL      2'h0
`define DOP_RST_HDISP     11'h140
`define DOP_RST_HNDP      11'h028
`define DOP_RST_VDISP     11'h0F0
`define DOP_RST_VNDP      11'h00A
`define DOP_LUT_DEPTH     64
`define DOP_FIFO_DEPTH    4
`endif

// file: pkg/dop_pkg.sv
// types shared by the display output path
package dop_pkg;
	// sub-registers behind the auto-incrementing gamma port
	typedef enum logic [1:0] {
		GS_ENABLE,
		GS_MODE,
		GS_INDEX,
		GS_DATA
	} dop_gsel_t;
	typedef logic [17:0] dop_pix_t;
endpackage : dop_pkg

// file: rtl/dop_top.sv
// display output path: apb registers, pixel fifo, gamma tables, timing and 18-bit pixel bus
//
// Function
// - normal order: red on bits 17..12, green 11..6, blue 5..0
// - swapped order: entire 18-bit output word bit-reversed
// - frame lasts horizontal total times vertical total pixel clocks
// - line lasts active width plus horizontal non-display clocks
// - frame lasts active height plus vertical non-display lines
// - each colour passes its own 64-entry gamma table indexed by value
// - gamma port sub-address auto-increments: enable, mode, index, data
// - successive data writes fill consecutive entries from the written index
//
// Design decisions made here: the placing of the registers and the APB register port.
`include "dop_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// small flop fifo; depth must be a power of two
module dop_fifo #(
	parameter int W = 18,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	// honest full and empty from the occupancy count
	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = ce & in_valid & in_ready;
	assign pop       = ce & out_valid & out_ready;

	// storage, written by index only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < D; i++) mem_q[i] <= '0;
		end else if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
			if (push && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule : dop_fifo

module dop_top #(
	parameter int CW = 11,
	parameter int FD = `DOP_FIFO_DEPTH
) (
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic           ce,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic [31:0]         prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           pix_in_valid,
	output logic                pix_in_ready,
	input  wire dop_pkg::dop_pix_t pix_in_data,
	output dop_pkg::dop_pix_t   pixel_out,
	output logic                pixel_de,
	output logic                frame_start
);
	import dop_pkg::*;

	logic [1:0]    ctrl_q;
	logic [CW-1:0] hdisp_q, hndp_q, vdisp_q, vndp_q;
	logic [CW-1:0] h_q, v_q;
	logic [CW:0]   htot, vtot;
	dop_gsel_t     gsel_q;
	logic          gam_en_q;
	logic [1:0]    gmode_q;
	logic [5:0]    gidx_q;
	logic [5:0]    lut_q [3][`DOP_LUT_DEPTH];
	logic          underrun_q, cap_q;
	logic          fifo_valid, active, wr, hit, h_end, v_end;
	dop_pix_t      fifo_data, corrected, mapped;
	logic [31:0]   rd_mux;

	// bit reversal of the whole pixel word
	function automatic dop_pix_t rev18(input dop_pix_t x);
		dop_pix_t r;
		r = '0;
		for (int i = 0; i < 18; i++) r[i] = x[17-i];
		return r;
	endfunction : rev18

	// apb slave: zero-wait once read data has been captured in setup
	assign pready  = ce & penable & cap_q;
	assign wr      = psel & penable & pwrite & pready;
	assign hit     = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
	assign pslverr = psel & penable & ~hit;

	// cap_q marks prdata valid; a stalled setup simply re-captures later
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_q  <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			cap_q  <= psel & ~(penable & cap_q);
			prdata <= psel ? rd_mux : prdata;
		end
	end

	// read decode; unmapped words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`DOP_OFF_CTRL:   rd_mux = {30'h0, ctrl_q};
			`DOP_OFF_HDISP:  rd_mux = 32'(hdisp_q);
			`DOP_OFF_HNDP:   rd_mux = 32'(hndp_q);
			`DOP_OFF_VDISP:  rd_mux = 32'(vdisp_q);
			`DOP_OFF_VNDP:   rd_mux = 32'(vndp_q);
			`DOP_OFF_GPTR:   rd_mux = {30'h0, gsel_q};
			`DOP_OFF_GPORT: begin
				unique case (gsel_q)
					GS_ENABLE: rd_mux = {31'h0, gam_en_q};
					GS_MODE:   rd_mux = {30'h0, gmode_q};
					GS_INDEX:  rd_mux = {26'h0, gidx_q};
					GS_DATA:   rd_mux = (gmode_q == 2'h3) ? 32'h0 : {26'h0, lut_q[gmode_q][gidx_q]};
				endcase
			end
			`DOP_OFF_STATUS: rd_mux = {29'h0, ~fifo_valid, underrun_q, v_q >= vdisp_q};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// plain configuration registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q  <= `DOP_RST_CTRL;
			hdisp_q <= `DOP_RST_HDISP;
			hndp_q  <= `DOP_RST_HNDP;
			vdisp_q <= `DOP_RST_VDISP;
			vndp_q  <= `DOP_RST_VNDP;
		end else if (wr) begin
			if (paddr == `DOP_OFF_CTRL) ctrl_q <= pwdata[1:0];
			if (paddr == `DOP_OFF_HDISP) hdisp_q <= pwdata[CW-1:0];
			if (paddr == `DOP_OFF_HNDP) hndp_q <= pwdata[CW-1:0];
			if (paddr == `DOP_OFF_VDISP) vdisp_q <= pwdata[CW-1:0];
			if (paddr == `DOP_OFF_VNDP) vndp_q <= pwdata[CW-1:0];
		end
	end

	// gamma port auto-increment
	// the port steps through enable, mode, index and then stays on data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gsel_q   <= GS_ENABLE;
			gam_en_q <= 1'b0;
			gmode_q  <= 2'h0;
		end else if (wr && paddr == `DOP_OFF_GPTR) begin
			gsel_q <= dop_gsel_t'(pwdata[1:0]);
		end else if (wr && paddr == `DOP_OFF_GPORT) begin
			if (gsel_q == GS_ENABLE) gam_en_q <= pwdata[0];
			if (gsel_q == GS_MODE) gmode_q <= pwdata[1:0];
			if (gsel_q != GS_DATA) gsel_q <= dop_gsel_t'(gsel_q + 2'h1);
		end
	end

	// consecutive table entries
	// index follows the last index write and advances once per data write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gidx_q <= 6'h00;
		end else if (wr && paddr == `DOP_OFF_GPORT) begin
			if (gsel_q == GS_INDEX) gidx_q <= pwdata[5:0];
			else if (gsel_q == GS_DATA) gidx_q <= gidx_q + 6'h01;
		end
	end

	// tables reset to identity; mode 3 selects no table so data writes drop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < 3; c++)
				for (int i = 0; i < `DOP_LUT_DEPTH; i++) lut_q[c][i] <= 6'(i);
		end else if (wr && paddr == `DOP_OFF_GPORT && gsel_q == GS_DATA && gmode_q != 2'h3) begin
			lut_q[gmode_q][gidx_q] <= pwdata[5:0];
		end
	end

	dop_fifo #(
		.W (18),
		.D (FD)
	) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.ce        (ce),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.in_data   (pix_in_data),
		.out_valid (fifo_valid),
		.out_ready (active),
		.out_data  (fifo_data)
	);

	assign htot   = {1'b0, hdisp_q} + {1'b0, hndp_q};
	assign vtot   = {1'b0, vdisp_q} + {1'b0, vndp_q};
	assign h_end  = ({1'b0, h_q} >= htot - 1'b1);
	assign v_end  = ({1'b0, v_q} >= vtot - 1'b1);
	assign active = ctrl_q[`DOP_CTRL_RUN] & (h_q < hdisp_q) & (v_q < vdisp_q);

	// frame rate from totals
	// raster counters; stopping the display parks them at the frame origin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			h_q <= '0;
			v_q <= '0;
		end else if (ce) begin
			if (!ctrl_q[`DOP_CTRL_RUN]) begin
				h_q <= '0;
				v_q <= '0;
			end else if (h_end) begin
				h_q <= '0;
				v_q <= v_end ? '0 : v_q + 1'b1;
			end else begin
				h_q <= h_q + 1'b1;
			end
		end
	end

	always_comb begin
		corrected = fifo_data;
		if (gam_en_q) begin
			corrected[17:12] = lut_q[0][fifo_data[17:12]];
			corrected[11:6]  = lut_q[1][fifo_data[11:6]];
			corrected[5:0]   = lut_q[2][fifo_data[5:0]];
		end
	end

	assign mapped = ctrl_q[`DOP_CTRL_SWAP] ? rev18(corrected) : corrected;

	// one pixel per active clock
	// an empty fifo in active time repeats the last pixel rather than glitch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pixel_out   <= '0;
			pixel_de    <= 1'b0;
			frame_start <= 1'b0;
		end else if (ce) begin
			if (active && fifo_valid) pixel_out <= mapped;
			pixel_de    <= active;
			frame_start <= ctrl_q[`DOP_CTRL_RUN] & (h_q == '0) & (v_q == '0);
		end
	end

	// sticky underrun, write one to clear; a new underrun wins over the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			underrun_q <= 1'b0;
		end else if (ce) begin
			if (active && !fifo_valid) underrun_q <= 1'b1;
			else if (wr && paddr == `DOP_OFF_STATUS && pwdata[`DOP_ST_UNDERRUN]) underrun_q <= 1'b0;
		end
	end

	// frame length checker: counts clocks between frame origins
	logic [31:0] fr_cnt_q;
	logic        fr_seen_q;
	logic        at_origin;
	assign at_origin = ce & ctrl_q[`DOP_CTRL_RUN] & (h_q == '0) & (v_q == '0);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fr_cnt_q  <= 32'h0000_0001;
			fr_seen_q <= 1'b0;
		end else if (ce) begin
			// bus traffic may retime the raster, so the count restarts on it
			if (psel || !ctrl_q[`DOP_CTRL_RUN]) begin
				fr_cnt_q  <= 32'h0000_0001;
				fr_seen_q <= 1'b0;
			end else begin
				fr_cnt_q  <= at_origin ? 32'h0000_0001 : fr_cnt_q + 32'h0000_0001;
				fr_seen_q <= fr_seen_q | at_origin;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	normal_order_a: assert property (
		ce && active && fifo_valid && !ctrl_q[0] |=> pixel_out == $past(corrected))
		else $error("normal order pixel mismatch");
	swap_order_a: assert property (
		ce && active && fifo_valid && ctrl_q[0] |=> pixel_out == rev18($past(corrected)))
		else $error("swapped order pixel mismatch");
	frame_rate_a: assert property (
		at_origin && fr_seen_q |-> fr_cnt_q == 32'(htot) * 32'(vtot))
		else $error("frame length differs from totals product");
	line_wrap_a: assert property (
		ce && ctrl_q[1] && h_end && !psel |=> h_q == '0 && !$stable(v_q) || vtot == 1)
		else $error("line did not wrap at horizontal total");
	frame_wrap_a: assert property (
		ce && ctrl_q[1] && h_end && v_end && !psel |=> v_q == '0 && h_q == '0)
		else $error("frame did not wrap at vertical total");
	red_lut_a: assert property (
		ce && active && fifo_valid && gam_en_q && !ctrl_q[0]
		|=> pixel_out[17:12] == $past(lut_q[0][fifo_data[17:12]]))
		else $error("red component bypassed gamma table");
	port_step_a: assert property (
		wr && paddr == 8'h18 && gsel_q != GS_DATA |=> gsel_q == $past(gsel_q) + 2'h1)
		else $error("gamma port did not advance");
	index_step_a: assert property (
		wr && paddr == 8'h18 && gsel_q == GS_DATA |=> gidx_q == $past(gidx_q) + 6'h01)
		else $error("gamma index did not advance");
	blank_hold_a: assert property (
		!active |=> $stable(pixel_out) && !pixel_de || !$past(ce))
		else $error("pixel bus changed outside active display");

	frame_seen_c: cover property (at_origin && fr_seen_q);
	swap_pixel_c: cover property (ce && active && fifo_valid && ctrl_q[0]);
	lut_load_c:   cover property (wr && paddr == 8'h18 && gsel_q == GS_DATA);
	fifo_full_c:  cover property (pix_in_valid && !pix_in_ready);
endmodule : dop_top
`default_nettype wire

// file: verification/dop_panel.sv
// panel model at the far side of the pixel bus: captures pixels, measures frames
`timescale 1ns/100ps
`default_nettype none
module dop_panel (
	input wire logic              clk,
	input wire logic              rst_b,
	input wire dop_pkg::dop_pix_t pixel_out,
	input wire logic              pixel_de,
	input wire logic              frame_start
);
	import dop_pkg::*;
	dop_pix_t cap[$];
	int       nfr;
	int       flen;
	int       dcnt;
	int       cyc_c;
	int       de_c;
	// a panel only latches while enable is high; frame length runs start pulse to start pulse
	// frame timing, capture
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nfr = 0;
			cyc_c = 0;
			de_c = 0;
		end else begin
			if (pixel_de)
				cap.push_back(pixel_out);
			if (frame_start) begin
				nfr++;
				flen = cyc_c;
				dcnt = de_c;
				cyc_c = 1;
				de_c = int'(pixel_de);
			end else begin
				cyc_c++;
				de_c += int'(pixel_de);
			end
		end
	end
endmodule : dop_panel
`default_nettype wire

// file: verification/tb_display_output_path.sv
// testbench of the display output path: apb setup, gamma load, pixel streaming
`include "dop_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_display_output_path;
	import dop_pkg::*;
	logic        clk;
	logic        rst_b;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pix_in_valid;
	logic        pix_in_ready;
	dop_pix_t    pix_in_data;
	dop_pix_t    pixel_out;
	logic        pixel_de;
	logic        frame_start;
	dop_pix_t    fq[$];
	dop_pix_t    sent[$];
	int          errors;
	int          compares;
	int          cyc;
	logic [31:0] r;
	logic        e;
	dop_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
		.pix_in_data(pix_in_data), .pixel_out(pixel_out), .pixel_de(pixel_de),
		.frame_start(frame_start));
	dop_panel panel (.clk(clk), .rst_b(rst_b), .pixel_out(pixel_out), .pixel_de(pixel_de),
		.frame_start(frame_start));
	// clock and reset held three cycles
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task complete_run;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd
	// gamma inverts red, flips green and blue by fixed masks, then the optional reversal
	function automatic dop_pix_t exp_pix(input dop_pix_t p, input logic sw);
		dop_pix_t v;
		v = {6'h3F - p[17:12], p[11:6] ^ 6'h15, p[5:0] ^ 6'h2A};
		if (sw)
			v = {<<{v}};
		return v;
	endfunction : exp_pix
	// feeder keeps valid up while pixels are queued; pops on an accepted edge
	always @(posedge clk) begin
		if (pix_in_valid && pix_in_ready)
			void'(fq.pop_front());
		pix_in_valid <= (fq.size() > 0);
		if (fq.size() > 0)
			pix_in_data <= fq[0];
	end
	// stream eight pixels and compare what the panel latched
	task stream(input logic sw, input int base);
		int i;
		for (i = 0; i < 8; i++) begin
			sent.push_back(dop_pix_t'({6'(i * 9 + base), 6'(i * 5 + 1), 6'(63 - i - base)}));
			fq.push_back(sent[i]);
		end
		wait (pix_in_ready === 1'b0);
		panel.cap.delete();
		apb(1'b1, `DOP_OFF_CTRL, {30'h0, 1'b1, sw});
		wait (panel.cap.size() >= 8);
		for (i = 0; i < 8; i++)
			chk(32'(panel.cap[i]), 32'(exp_pix(sent[i], sw)));
		sent.delete();
	endtask : stream
	initial begin
		{rst_b, ce, psel, penable, pwrite, paddr, pwdata} = '0;
		{errors, compares} = '0;
		ce = 1'b1;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rd(`DOP_OFF_HDISP, 32'(`DOP_RST_HDISP));
		rd(`DOP_OFF_VNDP, 32'(`DOP_RST_VNDP));
		rd(8'h20, 32'h0);
		chk(32'(e), 32'h1);
		// small raster: 4+2 clocks a line, 2+1 lines a frame
		apb(1'b1, `DOP_OFF_HDISP, 32'h4);
		apb(1'b1, `DOP_OFF_HNDP, 32'h2);
		apb(1'b1, `DOP_OFF_VDISP, 32'h2);
		apb(1'b1, `DOP_OFF_VNDP, 32'h1);
		// load red table while gamma is off
		apb(1'b1, `DOP_OFF_GPTR, 32'h0);
		apb(1'b1, `DOP_OFF_GPORT, 32'h0);
		apb(1'b1, `DOP_OFF_GPORT, 32'h0);
		apb(1'b1, `DOP_OFF_GPORT, 32'h0);
		for (int i = 0; i < 64; i++)
			apb(1'b1, `DOP_OFF_GPORT, 32'(63 - i));
		rd(`DOP_OFF_GPTR, 32'h3);
		apb(1'b1, `DOP_OFF_GPTR, 32'h2);
		apb(1'b1, `DOP_OFF_GPORT, 32'h5);
		rd(`DOP_OFF_GPORT, 32'h3A);
		rd(`DOP_OFF_GPORT, 32'h3A);
		// green and blue tables through modes 1 and 2, still with gamma off
		for (int m = 1; m < 3; m++) begin
			apb(1'b1, `DOP_OFF_GPTR, 32'h1);
			apb(1'b1, `DOP_OFF_GPORT, 32'(m));
			apb(1'b1, `DOP_OFF_GPORT, 32'h0);
			for (int i = 0; i < 64; i++)
				apb(1'b1, `DOP_OFF_GPORT, 32'(i ^ (m * 21)));
		end
		apb(1'b1, `DOP_OFF_GPTR, 32'h2);
		apb(1'b1, `DOP_OFF_GPORT, 32'h5);
		rd(`DOP_OFF_GPORT, 32'h2F);
		apb(1'b1, `DOP_OFF_GPTR, 32'h0);
		apb(1'b1, `DOP_OFF_GPORT, 32'h1);
		stream(1'b0, 3);
		wait (panel.nfr >= 3);
		chk(32'(panel.flen), 32'd18);
		chk(32'(panel.dcnt), 32'd8);
		apb(1'b1, `DOP_OFF_CTRL, 32'h0);
		apb(1'b0, `DOP_OFF_STATUS, 32'h0);
		chk(r & 32'h6, 32'h6);
		apb(1'b1, `DOP_OFF_STATUS, 32'h2);
		apb(1'b0, `DOP_OFF_STATUS, 32'h0);
		chk(r & 32'h2, 32'h0);
		// a low clock enable stalls the bus: pready waits until ce returns
		ce <= 1'b0;
		fork
			begin
				repeat (5) @(posedge clk);
				ce <= 1'b1;
			end
		join_none
		rd(`DOP_OFF_HDISP, 32'h4);
		stream(1'b1, 20);
		complete_run();
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			complete_run();
		end
	end
endmodule : tb_display_output_path
`default_nettype wire
